// [logic/ae_hit_detector.sv]
/*
  Acoustic emission hit detector with Avalon-MM register slave, hit
  timing in envelope mode and an 8 word FIFO of hit records.
  Assumes a 20 MHz clock, ADC sample stream on the same clock with a valid
  strobe, amplitudes already in dB, and a consumer with ready.
*/
`timescale 1ns/1ps
`include "ae_hit_params.svh"

module hit_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]      count, next_count;
  logic             push, pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    in_ready    = (count != (AW+1)'(DEPTH));
    out_valid   = (count != '0);
    out_data    = mem[rd_ptr];
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

module ae_hit_detector (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [7:0]  sample_amp_db,
  input  wire logic        sample_valid,
  output logic      [63:0] hit_data,
  output logic             hit_valid,
  input  wire logic        hit_ready,
  output logic             acquiring,
  output logic             sample_tick
);
  logic rst_meta, rst_sync;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Configuration and bus state
  logic                    running, next_running;
  ae_hit_pkg::acq_mode_t   mode, next_mode;
  logic [7:0]              threshold, next_threshold;
  logic [31:0]             gap_us, next_gap_us, forced_us, next_forced_us;
  logic [31:0]             lockout_us, next_lockout_us, rate_ksps, next_rate_ksps;
  logic [31:0]             rdata, next_rdata;
  logic                    wait_q, next_wait_q;
  logic [31:0]             hit_count, next_hit_count;
  logic                    dropped, next_dropped;
  logic                    fifo_in_ready;

  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                        input logic [31:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  ae_hit_pkg::hit_state_t  state, next_state;

  always_comb begin
    next_running    = running;
    next_mode       = mode;
    next_threshold  = threshold;
    next_gap_us     = gap_us;
    next_forced_us  = forced_us;
    next_lockout_us = lockout_us;
    next_rate_ksps  = rate_ksps;
    next_rdata      = rdata;
    next_wait_q     = 1'b1;
    // One wait cycle per access, answer on the second cycle
    if ((avs_read || avs_write) && wait_q) begin
      next_wait_q = 1'b0;
      if (avs_write) begin
        unique case (avs_address)
          `REG_CONTROL: begin
            if (avs_writedata[`CTRL_START_BIT]) next_running = 1'b1;
            if (avs_writedata[`CTRL_STOP_BIT]) next_running = 1'b0;
            next_mode = avs_writedata[`CTRL_MODE_BIT] ? ae_hit_pkg::mode_continuous
                                                      : ae_hit_pkg::mode_envelope;
          end
          `REG_THRESHOLD: next_threshold = avs_writedata[7:0];
          `REG_GAP:       next_gap_us = clamp(avs_writedata, `GAP_MIN_US, `GAP_MAX_US);
          `REG_FORCED:    next_forced_us = clamp(avs_writedata, `FORCED_MIN_US,
                                                 `FORCED_MAX_US);
          `REG_LOCKOUT:   next_lockout_us = clamp(avs_writedata, `LOCKOUT_MIN_US,
                                                  `LOCKOUT_MAX_US);
          `REG_RATE:      next_rate_ksps = clamp(avs_writedata, `RATE_MIN_KSPS,
                                                 `RATE_MAX_KSPS);
          default: ;
        endcase
      end else begin
        unique case (avs_address)
          `REG_CONTROL:   next_rdata = {29'h0, mode == ae_hit_pkg::mode_continuous,
                                        1'b0, running};
          `REG_THRESHOLD: next_rdata = {24'h0, threshold};
          `REG_GAP:       next_rdata = gap_us;
          `REG_FORCED:    next_rdata = forced_us;
          `REG_LOCKOUT:   next_rdata = lockout_us;
          `REG_RATE:      next_rdata = rate_ksps;
          `REG_STATUS:    next_rdata = {28'h0, dropped, ~fifo_in_ready, 
                                        state == ae_hit_pkg::st_in_hit, running};
          `REG_HIT_COUNT: next_rdata = hit_count;
          default:        next_rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      running    <= 1'b0;
      mode       <= ae_hit_pkg::mode_envelope;
      threshold  <= `RST_THRESHOLD;
      gap_us     <= `RST_GAP_US;
      forced_us  <= `RST_FORCED_US;
      lockout_us <= `RST_LOCKOUT_US;
      rate_ksps  <= `RST_RATE_KSPS;
      rdata      <= 32'h0000_0000;
      wait_q     <= 1'b1;
    end else begin
      running    <= next_running;
      mode       <= next_mode;
      threshold  <= next_threshold;
      gap_us     <= next_gap_us;
      forced_us  <= next_forced_us;
      lockout_us <= next_lockout_us;
      rate_ksps  <= next_rate_ksps;
      rdata      <= next_rdata;
      wait_q     <= next_wait_q;
    end
  end

  // Microsecond timebase and sample rate divider
  logic [4:0]  us_div, next_us_div;
  logic        us_tick;
  logic [31:0] rate_acc, next_rate_acc;
  logic        tick, next_tick;
  always_comb begin
    us_tick     = (us_div == 5'(`CYCLES_PER_US - 1));
    next_us_div = us_tick ? 5'h00 : us_div + 5'h01;
    // Accumulates the rate in samples per second each clock, wrapping at CLK_HZ
    next_tick     = 1'b0;
    next_rate_acc = rate_acc + rate_ksps * 32'd1000;
    if (next_rate_acc >= 32'(`CLK_HZ)) begin
      next_rate_acc = next_rate_acc - 32'(`CLK_HZ);
      next_tick     = running;
    end
  end
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      us_div   <= 5'h00;
      rate_acc <= 32'h0000_0000;
      tick     <= 1'b0;
    end else begin
      us_div   <= next_us_div;
      rate_acc <= next_rate_acc;
      tick     <= next_tick;
    end
  end

  // Hit timing
  logic [31:0] now_us, next_now_us;
  logic [31:0] hit_start, next_hit_start, hit_len, next_hit_len;
  logic [31:0] gap_cnt, next_gap_cnt, lock_cnt, next_lock_cnt;
  logic        above;
  logic        emit;
  ae_hit_pkg::hit_record_t rec;
  always_comb begin
    next_state     = state;
    next_now_us    = now_us + 32'(us_tick);
    next_hit_start = hit_start;
    next_hit_len   = hit_len;
    next_gap_cnt   = gap_cnt;
    next_lock_cnt  = lock_cnt;
    next_hit_count = hit_count;
    next_dropped   = dropped;
    emit           = 1'b0;
    above          = sample_valid && running && (sample_amp_db > threshold);
    rec.start_us    = hit_start;
    rec.duration_us = hit_len;
    if ((avs_read || avs_write) && wait_q && avs_read && avs_address == `REG_STATUS) begin
      next_dropped = 1'b0;
    end
    unique case (state)
      ae_hit_pkg::st_idle: begin
        // Threshold unused in continuous mode
        if (mode == ae_hit_pkg::mode_envelope && above) begin
          next_state     = ae_hit_pkg::st_in_hit;
          next_hit_start = now_us;
          next_hit_len   = 32'h0000_0000;
          next_gap_cnt   = 32'h0000_0000;
        end
      end
      ae_hit_pkg::st_in_hit: begin
        if (us_tick) begin
          next_hit_len = hit_len + 32'h0000_0001;
          next_gap_cnt = gap_cnt + 32'h0000_0001;
        end
        if (above) begin
          next_gap_cnt = 32'h0000_0000;
        end
        if (mode == ae_hit_pkg::mode_continuous || !running) begin
          next_state = ae_hit_pkg::st_idle;
        end else if (next_hit_len >= forced_us) begin
          emit          = 1'b1;
          rec.duration_us = forced_us;
          next_state    = ae_hit_pkg::st_lockout;
          next_lock_cnt = 32'h0000_0000;
        end else if (next_gap_cnt >= gap_us) begin
          emit            = 1'b1;
          rec.duration_us = next_hit_len - gap_us;
          next_state      = ae_hit_pkg::st_lockout;
          next_lock_cnt   = 32'h0000_0000;
        end
      end
      ae_hit_pkg::st_lockout: begin
        if (us_tick) begin
          next_lock_cnt = lock_cnt + 32'h0000_0001;
        end
        if (next_lock_cnt >= lockout_us || mode == ae_hit_pkg::mode_continuous) begin
          next_state = ae_hit_pkg::st_idle;
        end
      end
    endcase
    if (emit) begin
      next_hit_count = hit_count + 32'h0000_0001;
      if (!fifo_in_ready) begin
        next_dropped = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state     <= ae_hit_pkg::st_idle;
      now_us    <= 32'h0000_0000;
      hit_start <= 32'h0000_0000;
      hit_len   <= 32'h0000_0000;
      gap_cnt   <= 32'h0000_0000;
      lock_cnt  <= 32'h0000_0000;
      hit_count <= 32'h0000_0000;
      dropped   <= 1'b0;
    end else begin
      state     <= next_state;
      now_us    <= next_now_us;
      hit_start <= next_hit_start;
      hit_len   <= next_hit_len;
      gap_cnt   <= next_gap_cnt;
      lock_cnt  <= next_lock_cnt;
      hit_count <= next_hit_count;
      dropped   <= next_dropped;
    end
  end

  // Records buffered in the fifo; output registered in the stage after it
  logic [63:0] fifo_out;
  logic        fifo_out_valid, take;
  hit_fifo #(
    .WIDTH (64),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_sync),
    .in_data   (rec),
    .in_valid  (emit),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (take)
  );

  logic [63:0] next_hit_data;
  logic        next_hit_valid;
  always_comb begin
    take           = fifo_out_valid && (!hit_valid || hit_ready);
    next_hit_valid = take ? 1'b1 : (hit_ready ? 1'b0 : hit_valid);
    next_hit_data  = take ? fifo_out : hit_data;
  end
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      hit_data  <= 64'h0;
      hit_valid <= 1'b0;
      acquiring <= 1'b0;
      sample_tick <= 1'b0;
      avs_readdata <= 32'h0;
      avs_waitrequest <= 1'b1;
    end else begin
      hit_data  <= next_hit_data;
      hit_valid <= next_hit_valid;
      acquiring <= running;
      sample_tick <= tick;
      avs_readdata <= next_rdata;
      avs_waitrequest <= next_wait_q;
    end
  end
endmodule

// [logic/ae_hit_params.svh]
/*
  Constants for the acoustic emission hit detector: timing limits, reset
  values and the register map. Assumes a 20 MHz system clock.
*/
`ifndef AE_HIT_PARAMS_SVH
`define AE_HIT_PARAMS_SVH

`define CLK_HZ            20000000
`define US_NS             1000
`define CLK_PERIOD_NS     50
`define CYCLES_PER_US     (`US_NS / `CLK_PERIOD_NS)

`define GAP_MIN_US        32'd100
`define GAP_MAX_US        32'd50000
`define FORCED_MIN_US     32'd1
`define FORCED_MAX_US     32'd50000
`define LOCKOUT_MIN_US    32'd1
`define LOCKOUT_MAX_US    32'd20000000
`define RATE_MIN_KSPS     32'd1
`define RATE_MAX_KSPS     32'd20000

`define REG_CONTROL       8'h00
`define REG_THRESHOLD     8'h04
`define REG_GAP           8'h08
`define REG_FORCED        8'h0C
`define REG_LOCKOUT       8'h10
`define REG_RATE          8'h14
`define REG_STATUS        8'h18
`define REG_HIT_COUNT     8'h1C

`define CTRL_START_BIT    0
`define CTRL_STOP_BIT     1
`define CTRL_MODE_BIT     2

`define RST_THRESHOLD     8'h2D
`define RST_GAP_US        32'd800
`define RST_FORCED_US     32'd10000
`define RST_LOCKOUT_US    32'd1000
`define RST_RATE_KSPS     32'd1000

`define FIFO_DEPTH        8
`define FIFO_AW           3

`endif

// [logic/ae_hit_pkg.sv]
/*
  Types for the acoustic emission hit detector.
  Assumes ae_hit_params.svh is compiled alongside.
*/
package ae_hit_pkg;
  typedef enum logic {mode_envelope, mode_continuous} acq_mode_t;
  typedef enum logic [1:0] {st_idle, st_in_hit, st_lockout} hit_state_t;
  typedef struct packed {
    logic [31:0] start_us;
    logic [31:0] duration_us;
  } hit_record_t;
endpackage

// [sim/adc_model.sv]
/*
  Behavioural converter: one sample per tick, above threshold or at most at it.
  Assumes a random byte from the bench and the default threshold.
*/
`timescale 1ns/1ps
module adc_model (
  input  wire logic       clk,
  input  wire logic       sample_tick,
  input  wire logic       level,
  input  wire logic [7:0] rnd,
  output logic            sample_valid,
  output logic      [7:0] sample_amp_db
);
  initial begin
    sample_valid  = 1'b0;
    sample_amp_db = 8'h00;
  end
  // Low samples reach the threshold itself, never beyond
  always @(posedge clk) begin
    sample_valid <= sample_tick;
    if (sample_tick)
      sample_amp_db <= level ? 8'h2E + {1'b0, rnd[6:0]} : 8'h0E + {3'h0, rnd[4:0]};
    else
      sample_amp_db <= ~sample_amp_db;
  end
endmodule

// [sim/ae_hit_checker.sv]
/*
  Port-level checker for the hit detector, bound to its top module.
  Assumes the default 1000 ksps rate on a 20 MHz clock.
*/
`timescale 1ns/1ps
`include "ae_hit_params.svh"
module ae_hit_checker (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [7:0]  sample_amp_db,
  input wire logic        sample_valid,
  input wire logic [63:0] hit_data,
  input wire logic        hit_valid,
  input wire logic        hit_ready,
  input wire logic        acquiring,
  input wire logic        sample_tick
);
  logic [7:0] tick_cnt;
  logic [7:0] next_tick_cnt;
  logic       seen;
  logic       next_seen;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Cycles since last tick while running
  always_comb begin
    next_tick_cnt = sample_tick ? 8'h00 : tick_cnt + 8'h01;
    next_seen     = acquiring & (seen | sample_tick);
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt <= 8'h00;
      seen     <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      seen     <= next_seen;
    end
  end
  property p_reset_idle;
    $rose(reset_n) |-> avs_waitrequest && !hit_valid && !acquiring;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
  property p_wait_ack;
    $rose(avs_read || avs_write) |-> ##[1:2] !avs_waitrequest;
  endproperty
  a_wait_ack: assert property (p_wait_ack) else $error("bus answer late");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer held too long");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address > `REG_HIT_COUNT |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_start;
    avs_write && !avs_waitrequest && avs_address == `REG_CONTROL
      && avs_writedata[1:0] == 2'h1 |-> ##[1:3] acquiring;
  endproperty
  a_start: assert property (p_start) else $error("start did not run");
  property p_stop;
    avs_write && !avs_waitrequest && avs_address == `REG_CONTROL
      && avs_writedata[1:0] == 2'h2 |-> ##[1:3] !acquiring;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not halt");
  property p_hold;
    hit_valid && !hit_ready |=> hit_valid && $stable(hit_data);
  endproperty
  a_hold: assert property (p_hold) else $error("record changed before taken");
  property p_dur_max;
    hit_valid |-> hit_data[31:0] <= `FORCED_MAX_US;
  endproperty
  a_dur_max: assert property (p_dur_max) else $error("duration beyond forced end");
  // Tick every 20 cycles at 1000 ksps
  property p_rate;
    sample_tick && seen |-> tick_cnt == 8'h13;
  endproperty
  a_rate: assert property (p_rate) else $error("sample tick spacing wrong");
endmodule

bind ae_hit_detector ae_hit_checker chk (.clk(clk), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .sample_amp_db(sample_amp_db),
  .sample_valid(sample_valid), .hit_data(hit_data), .hit_valid(hit_valid),
  .hit_ready(hit_ready), .acquiring(acquiring), .sample_tick(sample_tick));

// [sim/testbench.sv]
/*
  Self-checking bench: register bus, hit timing, record buffer.
  Assumes the design and adc_model compiled before it.
*/
`timescale 1ns/1ps
`include "ae_hit_params.svh"
module testbench;
  logic        clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0]  avs_address = 8'h00, rnd = 8'h00, sample_amp_db;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, e, cnt, last_start = 32'h0;
  logic        avs_waitrequest, sample_valid, hit_valid, acquiring, sample_tick;
  logic        hit_ready = 1'b0, level = 1'b0, drain = 1'b1;
  logic [63:0] hit_data;
  logic [31:0] exp_q[$];
  logic [31:0] rst_v[5] = '{32'(`RST_THRESHOLD), `RST_GAP_US, `RST_FORCED_US,
                            `RST_LOCKOUT_US, `RST_RATE_KSPS};
  int          errors = 0, n_checks = 0, seed = 79227;

  ae_hit_detector dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sample_amp_db(sample_amp_db), .sample_valid(sample_valid), .hit_data(hit_data),
    .hit_valid(hit_valid), .hit_ready(hit_ready), .acquiring(acquiring),
    .sample_tick(sample_tick));
  adc_model adc (.clk(clk), .sample_tick(sample_tick), .level(level), .rnd(rnd),
    .sample_valid(sample_valid), .sample_amp_db(sample_amp_db));

  always #25 clk = ~clk;
  always @(posedge clk) begin
    rnd       <= 8'($random(seed));
    hit_ready <= drain & (rnd[0] | rnd[1]);
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task close_out;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic set_chk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] x,
                         input string what);
    bus_wr(a, d);
    bus_rd(a, rd);
    check(what, rd, x);
  endtask

  task automatic hold(input int us);
    repeat (us * `CYCLES_PER_US) @(posedge clk);
  endtask

  task automatic burst(input int hi, input int lo);
    level <= 1'b1;
    hold(hi);
    level <= 1'b0;
    hold(lo);
  endtask

  // Oldest note against each accepted record
  always @(posedge clk) begin
    if (hit_valid === 1'b1 && hit_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("spare record", 32'h1, 32'h0);
      end else begin
        e = exp_q.pop_front();
        if (e !== 32'hFFFFFFFF)
          check("duration", hit_data[31:0], e);
        check("start order", {31'h0, hit_data[63:32] > last_start}, 32'h1);
        last_start = hit_data[63:32];
      end
    end
  end

  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    close_out;
  end

  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      bus_rd(8'(`REG_THRESHOLD + 4 * i), rd);
      check("reset value", rd, rst_v[i]);
    end
    set_chk(8'h20, 32'hFFFFFFFF, 32'h0, "unmapped");
    set_chk(`REG_GAP, 32'h32, `GAP_MIN_US, "gap clamp");
    set_chk(`REG_GAP, 32'h64, 32'h64, "gap");
    set_chk(`REG_FORCED, 32'h0, `FORCED_MIN_US, "forced low clamp");
    set_chk(`REG_FORCED, 32'hEA61, `FORCED_MAX_US, "forced high clamp");
    set_chk(`REG_LOCKOUT, 32'hFFFFFFFF, `LOCKOUT_MAX_US, "lockout clamp");
    set_chk(`REG_FORCED, 32'h14, 32'h14, "forced");
    set_chk(`REG_LOCKOUT, 32'h12C, 32'h12C, "lockout");
    bus_wr(`REG_CONTROL, 32'h1);
    hold(1);
    check("running", {31'h0, acquiring}, 32'h1);
    // Held above threshold past the forced end
    exp_q.push_back(32'h14);
    burst(30, 400);
    // Second crossing falls inside lockout
    exp_q.push_back(32'hFFFFFFFF);
    burst(10, 150);
    burst(10, 450);
    set_chk(`REG_LOCKOUT, 32'h1, 32'h1, "lockout short");
    set_chk(`REG_FORCED, 32'h3E8, 32'h3E8, "forced long");
    // Crossings 60 us apart merge, 160 us apart split
    exp_q.push_back(32'hFFFFFFFF);
    burst(10, 50);
    burst(10, 200);
    repeat (2) exp_q.push_back(32'hFFFFFFFF);
    burst(10, 150);
    burst(10, 200);
    bus_rd(`REG_HIT_COUNT, rd);
    check("hit count", rd, 32'h5);
    // Consumer stalls until the buffer refuses: eight queued, one held at the output
    drain <= 1'b0;
    repeat (10) burst(10, 120);
    repeat (9) exp_q.push_back(32'hFFFFFFFF);
    bus_rd(`REG_STATUS, rd);
    check("full and dropped", {30'h0, rd[3:2]}, 32'h3);
    drain <= 1'b1;
    for (int i = 0; i < 2000 && exp_q.size() > 0; i++) @(posedge clk);
    check("drained", 32'(exp_q.size()), 32'h0);
    // Continuous mode ignores threshold and forced end: no records
    bus_rd(`REG_HIT_COUNT, cnt);
    bus_wr(`REG_CONTROL, 32'h5);
    burst(30, 200);
    bus_rd(`REG_CONTROL, rd);
    check("mode", rd, 32'h5);
    bus_rd(`REG_HIT_COUNT, rd);
    check("continuous hit count", rd, cnt);
    bus_wr(`REG_CONTROL, 32'h2);
    hold(1);
    check("stopped", {31'h0, acquiring}, 32'h0);
    burst(10, 200);
    close_out;
  end
endmodule
